// >>> elpc_top.v
// External LNA/PA front-end control with Wishbone register access
`timescale 1ns/1ps
`include "elpc_regs.vh"
module elpc_top #(
   parameter STEP_CYC = `ELPC_STEP_CYC
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [9:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   output wire        err_o,
   input  wire        rx_settled_i,
   output reg         lna_pin_o,
   output reg         pa_pin_o,
   output wire        rx_valid_o,
   output wire        tx_access_o,
   output wire [2:0]  radio_state_o
);
   // ************************************************************
   // Registers
   // ************************************************************
   reg  [7:0] ext_lna_config;
   reg  [7:0] ext_pa_config;
   reg  [7:0] tx_powerup_to_access;
   reg  [7:0] seq_ctrl;
   reg  [2:0] radio_state_field;
   reg        rx_settled_s1;
   reg        rx_settled_s2;

   wire lna_polarity       = ext_lna_config[`ELPC_POL_BIT];
   wire lna_pin_enable     = ext_lna_config[`ELPC_EN_BIT];
   wire [4:0] lna_settle_delay   = ext_lna_config[`ELPC_DLY_MSB:0];
   wire pa_polarity        = ext_pa_config[`ELPC_POL_BIT];
   wire pa_pin_enable      = ext_pa_config[`ELPC_EN_BIT];
   wire [4:0] pa_settle_to_access = ext_pa_config[`ELPC_DLY_MSB:0];
   wire [4:0] tx_settle_to_access = tx_powerup_to_access[`ELPC_DLY_MSB:0];
   wire tx_req  = seq_ctrl[`ELPC_CTRL_TXREQ];
   wire rx_req  = seq_ctrl[`ELPC_CTRL_RXREQ];
   wire sleep   = seq_ctrl[`ELPC_CTRL_SLEEP];

   // ************************************************************
   // Wishbone slave, one wait state, byte lane 0 only
   // ************************************************************
   wire req     = cyc_i && stb_i && !ack_o;
   wire wr_lane = req && we_i && sel_i[0];
   reg  [7:0] rd_byte;
   assign err_o = 1'b0;

   always @* begin
      case (adr_i)
         `ELPC_ADDR_OPERATION_STATUS: rd_byte = {5'h00, radio_state_field};
         `ELPC_ADDR_TX2ACC:   rd_byte = tx_powerup_to_access;
         `ELPC_ADDR_EXT_PA_CONFIG:    rd_byte = ext_pa_config;
         `ELPC_ADDR_EXT_LNA_CONFIG:   rd_byte = ext_lna_config;
         `ELPC_ADDR_CTRL:     rd_byte = seq_ctrl;
         default:             rd_byte = 8'h00;
      endcase
   end

   // Sleep only gates sequencing; registers keep their values through it
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o                <= 1'b0;
         dat_o                <= 32'h0000_0000;
         ext_lna_config       <= `ELPC_EXT_LNA_CONFIG_RST;
         ext_pa_config        <= `ELPC_EXT_PA_CONFIG_RST;
         tx_powerup_to_access <= `ELPC_TX2ACC_RST;
         seq_ctrl             <= `ELPC_CTRL_RST;
      end else begin
         ack_o <= req;
         dat_o <= req ? {24'h000000, rd_byte} : 32'h0000_0000;
         if (wr_lane) begin
            case (adr_i)
               `ELPC_ADDR_EXT_LNA_CONFIG: ext_lna_config <= dat_i[7:0] & `ELPC_CFG_MASK;
               `ELPC_ADDR_EXT_PA_CONFIG:  ext_pa_config  <= dat_i[7:0] & `ELPC_CFG_MASK;
               `ELPC_ADDR_TX2ACC: tx_powerup_to_access <= dat_i[7:0] & `ELPC_TX2ACC_MASK;
               `ELPC_ADDR_CTRL:   seq_ctrl <= dat_i[7:0] & 8'h07;
               default:           seq_ctrl <= seq_ctrl;
            endcase
         end
      end
   end

   // ************************************************************
   // Autonomous power-mode sequencer
   // ************************************************************
   localparam S_IDLE   = 3'h0;
   localparam S_TXUP   = 3'h1;
   localparam S_TXGO   = 3'h2;
   localparam S_RXUP   = 3'h3;
   localparam S_RXGO   = 3'h4;
   localparam S_SLEEP  = 3'h5;

   reg  [2:0] state;
   reg  [2:0] next_state;
   reg        tmr_start;
   reg  [4:0] tmr_steps;
   wire       tmr_done;

   elpc_settle_timer #(.STEP_CYC(STEP_CYC)) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (tmr_start),
      .steps_i (tmr_steps),
      .done_o  (tmr_done)
   );

   // Receiver settle is its own input; the LNA wait counts only when the pin is driven
   wire [4:0] rx_wait = lna_pin_enable ? lna_settle_delay : 5'h00;
   // With PA used, medium access waits the longer of TX and PA settle
   wire [4:0] tx_wait = (pa_pin_enable && pa_settle_to_access > tx_settle_to_access) ?
                        pa_settle_to_access : tx_settle_to_access;

   always @* begin
      next_state = state;
      tmr_start  = 1'b0;
      tmr_steps  = 5'h00;
      case (state)
         S_IDLE: begin
            if (sleep) begin
               next_state = S_SLEEP;
            end else if (tx_req) begin
               next_state = S_TXUP;
               tmr_start  = 1'b1;
               tmr_steps  = tx_wait;
            end else if (rx_req) begin
               next_state = S_RXUP;
               tmr_start  = 1'b1;
               tmr_steps  = rx_wait;
            end
         end
         S_TXUP: begin
            if (!tx_req) begin
               next_state = S_IDLE;
            end else if (tmr_done) begin
               next_state = S_TXGO;
            end
         end
         S_TXGO: begin
            if (!tx_req) begin
               next_state = rx_req ? S_RXUP : S_IDLE;
               tmr_start  = rx_req;
               tmr_steps  = rx_wait;
            end
         end
         S_RXUP: begin
            if (!rx_req) begin
               next_state = S_IDLE;
            end else if (tmr_done && rx_settled_s2) begin
               next_state = S_RXGO;
            end
         end
         S_RXGO: begin
            if (!rx_req) begin
               next_state = S_IDLE;
            end
         end
         S_SLEEP: begin
            if (!sleep) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state         <= S_IDLE;
         rx_settled_s1 <= 1'b0;
         rx_settled_s2 <= 1'b0;
      end else begin
         state         <= next_state;
         rx_settled_s1 <= rx_settled_i;
         rx_settled_s2 <= rx_settled_s1;
      end
   end

   // ************************************************************
   // Pins and status
   // ************************************************************
   wire lna_need = (state == S_RXUP) || (state == S_RXGO);
   wire pa_need  = (state == S_TXUP) || (state == S_TXGO);
   wire lna_on   = lna_need && lna_pin_enable;
   wire pa_on    = pa_need && pa_pin_enable;

   // Pins rest at the inactive level of the reset polarity, so no amplifier switches on during reset
   localparam [7:0] LNA_CFG_RST = `ELPC_EXT_LNA_CONFIG_RST;
   localparam [7:0] PA_CFG_RST  = `ELPC_EXT_PA_CONFIG_RST;

   always @(posedge clk_i) begin
      if (rst_i) begin
         lna_pin_o         <= ~LNA_CFG_RST[`ELPC_POL_BIT];
         pa_pin_o          <= ~PA_CFG_RST[`ELPC_POL_BIT];
         radio_state_field <= `ELPC_RF_IDLE;
      end else begin
         lna_pin_o <= lna_on ? lna_polarity : ~lna_polarity;
         pa_pin_o  <= pa_on ? pa_polarity : ~pa_polarity;
         case (state)
            S_TXGO:  radio_state_field <= pa_on ? `ELPC_RF_TX_PA : `ELPC_RF_TX;
            S_RXGO:  radio_state_field <= lna_on ? `ELPC_RF_RX_LNA : `ELPC_RF_RX;
            S_TXUP,
            S_RXUP:  radio_state_field <= (pa_on || lna_on) ? `ELPC_RF_SYNTH_AMP : `ELPC_RF_SYNTH;
            S_SLEEP: radio_state_field <= `ELPC_RF_SLEEP;
            default: radio_state_field <= `ELPC_RF_IDLE;
         endcase
      end
   end

   assign rx_valid_o    = (state == S_RXGO);
   assign tx_access_o   = (state == S_TXGO);
   assign radio_state_o = radio_state_field;
endmodule

// >>> elpc_regs.vh
// Register map, field layout, reset values and timing constants of the amplifier control block
// Summary of operation
// - LNA pin active level is high when polarity bit is 1, low when 0.
// - LNA control signal reaches the pin only while the pin enable bit is set.
// - Five-bit LNA settle field sets wait in 1 us steps, no offset.
// - LNA and receiver start together; reception valid after the longer settle.
// - Top bit of LNA config is reserved; host writes zero, reads return zero.
// - CSMA sending steps power modes autonomously, switching PA and LNA as needed.
// - Deep sleep keeps all register contents and calibration state.
// - LNA pin goes active while receive path needs it, inactive otherwise.
// - PA pin goes active while transmission needs it, inactive otherwise.
// - Radio state field reports 111 TX+PA, 110 RX+LNA, 101 synth+PA/LNA.
// - Wait PA settle field in 1 us steps after PA on before medium access.
`ifndef ELPC_REGS_VH
`define ELPC_REGS_VH

// ************************************************************
// Register byte addresses (index times four)
// ************************************************************
`define ELPC_IDX_OPERATION_STATUS   8'h02
`define ELPC_IDX_TX2ACC     8'h3c
`define ELPC_IDX_EXT_PA_CONFIG      8'h3d
`define ELPC_IDX_EXT_LNA_CONFIG     8'h3e
`define ELPC_IDX_CTRL       8'h40
`define ELPC_ADDR_OPERATION_STATUS  10'h008
`define ELPC_ADDR_TX2ACC    10'h0f0
`define ELPC_ADDR_EXT_PA_CONFIG     10'h0f4
`define ELPC_ADDR_EXT_LNA_CONFIG    10'h0f8
`define ELPC_ADDR_CTRL      10'h100

// ************************************************************
// Fields and reset values
// ************************************************************
`define ELPC_POL_BIT        6
`define ELPC_EN_BIT         5
`define ELPC_DLY_MSB        4
`define ELPC_CFG_MASK       8'h7f
`define ELPC_TX2ACC_MASK    8'h1f
`define ELPC_EXT_LNA_CONFIG_RST     8'h04
`define ELPC_EXT_PA_CONFIG_RST      8'h04
`define ELPC_TX2ACC_RST     8'h03
`define ELPC_CTRL_RST       8'h00
`define ELPC_CTRL_TXREQ     0
`define ELPC_CTRL_RXREQ     1
`define ELPC_CTRL_SLEEP     2

// ************************************************************
// Radio state encodings
// ************************************************************
`define ELPC_RF_IDLE        3'h0
`define ELPC_RF_SYNTH_AMP   3'h5
`define ELPC_RF_RX_LNA      3'h6
`define ELPC_RF_TX_PA       3'h7
`define ELPC_RF_SYNTH       3'h1
`define ELPC_RF_RX          3'h2
`define ELPC_RF_TX          3'h3
`define ELPC_RF_SLEEP       3'h4

// ************************************************************
// Timing
// ************************************************************
`define ELPC_CLK_MHZ        250
`define ELPC_STEP_NS        1000
`define ELPC_CLK_NS         4
`define ELPC_STEP_CYC       (`ELPC_STEP_NS / `ELPC_CLK_NS)
`define ELPC_RX_SETTLE_US   5'h02

`endif

// >>> elpc_settle_timer.v
// Microsecond settle timer: counts a loaded number of 1 us steps
`timescale 1ns/1ps
module elpc_settle_timer #(
   parameter STEP_CYC = 250
) (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       start_i,
   input  wire [4:0] steps_i,
   output wire       done_o
);
   reg [4:0] steps;
   reg [8:0] tick;

   // Zero steps means ready at once: the field has no offset
   assign done_o = (steps == 5'h00) && !start_i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         steps <= 5'h00;
         tick  <= 9'h000;
      end else if (start_i) begin
         steps <= steps_i;
         tick  <= 9'h000;
      end else if (steps != 5'h00) begin
         if (tick == STEP_CYC - 1) begin
            tick  <= 9'h000;
            steps <= steps - 5'h01;
         end else begin
            tick <= tick + 9'h001;
         end
      end
   end
endmodule

// >>> elpc_asserts.sv
// Port checker for the amplifier control block
`timescale 1ns/1ps
`include "elpc_regs.vh"
module elpc_asserts (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [9:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        rx_settled_i,
   input wire logic        rx_valid_o,
   input wire logic        tx_access_o,
   input wire logic [2:0]  radio_state_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_answer;
      ack_o ##1 (!ack_o && dat_o == 32'h0);
   endsequence
   chk_ack_once: assert property (s_take |=> s_answer)
      else $error("ack not a single cycle answer");
   chk_rsv_zero: assert property (ack_o && !we_i && adr_i == `ELPC_ADDR_EXT_LNA_CONFIG |-> !dat_o[7])
      else $error("reserved bit read as one");
   chk_err_low: assert property (!err_o)
      else $error("error response raised");
   // Sync stage and state register put three edges between the settle input and validity
   chk_valid_settled: assert property ($rose(rx_valid_o) |-> $past(rx_settled_i, 3))
      else $error("reception valid before receiver settled");
   // Status field is the registered image of the state, one edge behind the valid flags
   chk_valid_state: assert property ($past(rx_valid_o) |-> radio_state_o inside {`ELPC_RF_RX, `ELPC_RF_RX_LNA})
      else $error("reception valid outside receive state");
   chk_access_state: assert property ($past(tx_access_o) |-> radio_state_o inside {`ELPC_RF_TX, `ELPC_RF_TX_PA})
      else $error("medium access outside transmit state");
   chk_no_both: assert property (!(rx_valid_o && tx_access_o))
      else $error("receive and transmit active together");
   chk_sleep_quiet: assert property (radio_state_o == `ELPC_RF_SLEEP |-> !rx_valid_o && !tx_access_o)
      else $error("activity while asleep");
endmodule

// >>> elpc_rx_front.sv
// Receiver settle model that answers a programmable number of cycles after switch-on
`timescale 1ns/1ps
module elpc_rx_front (
   input  wire logic       clk_i,
   input  wire logic       on_i,
   input  wire logic [7:0] wait_i,
   output logic            settled_o
);
   logic [7:0] cnt;
   // Settle drops at once when switched off, as a real receiver does
   always @(posedge clk_i) begin
      if (!on_i)
         cnt <= 8'h00;
      else if (cnt != wait_i)
         cnt <= cnt + 8'h01;
   end
   assign settled_o = on_i && cnt == wait_i;
endmodule

// >>> elpc_top_tb_top.sv
// Self-checking bench for the amplifier control block
`timescale 1ns/1ps
`include "elpc_regs.vh"
module elpc_top_tb_top;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, fe_on;
   logic [9:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, q;
   logic [7:0]  fe_wait;
   wire  [31:0] dat_o;
   wire         ack_o, err_o, rx_settled_i, lna_pin_o, pa_pin_o, rx_valid_o, tx_access_o;
   wire  [2:0]  radio_state_o;
   int          n_mismatch, checked, n;
   // Short step keeps the microsecond waits to a few cycles each
   elpc_top #(.STEP_CYC(4)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
      .ack_o, .err_o, .rx_settled_i, .lna_pin_o, .pa_pin_o, .rx_valid_o, .tx_access_o, .radio_state_o);
   elpc_rx_front fe (.clk_i, .on_i(fe_on), .wait_i(fe_wait), .settled_o(rx_settled_i));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task wrap_up;
      $display("Checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      sel_i <= s;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 20)
         chk("bus ack", 32'h0, 32'h1);
   endtask
   task wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask
   task rd(input logic [9:0] a);
      bus(1'b0, a, 8'h00, 4'hf);
   endtask
   task wait_hi(input bit tx);
      n = 0;
      while (((tx ? tx_access_o : rx_valid_o) !== 1'b1) && n < 400) begin
         @(negedge clk_i);
         n++;
      end
      // Status field trails the state by one edge
      @(negedge clk_i);
   endtask
   task t_reset;
      rd(`ELPC_ADDR_EXT_LNA_CONFIG); chk("lna cfg", q, 32'h04);
      rd(`ELPC_ADDR_EXT_PA_CONFIG); chk("pa cfg", q, 32'h04);
      rd(`ELPC_ADDR_TX2ACC); chk("tx settle", q, 32'h03);
      rd(10'h3fc); chk("unmapped", q, 32'h0);
      chk("lna idle", lna_pin_o, 32'h1);
      chk("pa idle", pa_pin_o, 32'h1);
      chk("idle flags", {rx_valid_o, tx_access_o}, 32'h0);
      rd(`ELPC_ADDR_OPERATION_STATUS); chk("idle state", q, 32'h0);
   endtask
   task t_regs;
      wr(`ELPC_ADDR_EXT_LNA_CONFIG, 8'h7f);
      rd(`ELPC_ADDR_EXT_LNA_CONFIG); chk("lna rsv", q, 32'h7f);
      bus(1'b1, `ELPC_ADDR_EXT_LNA_CONFIG, 8'h00, 4'h0);
      wr(`ELPC_ADDR_CTRL, 8'h04);
      rd(`ELPC_ADDR_OPERATION_STATUS); chk("sleep state", q, 32'h4);
      rd(`ELPC_ADDR_EXT_LNA_CONFIG); chk("sleep keep", q, 32'h7f);
      wr(`ELPC_ADDR_CTRL, 8'h00);
   endtask
   task t_rx(input logic [7:0] cfg, input int lo, input int hi, input logic [7:0] fw);
      wr(`ELPC_ADDR_EXT_LNA_CONFIG, cfg);
      fe_wait <= fw;
      fe_on <= 1'b1;
      wr(`ELPC_ADDR_CTRL, 8'h02);
      wait_hi(1'b0);
      chk("rx wait", n >= lo && n <= hi, 32'h1);
      chk("lna on", lna_pin_o, cfg[5] ? cfg[6] : !cfg[6]);
      chk("rx state", radio_state_o, cfg[5] ? `ELPC_RF_RX_LNA : `ELPC_RF_RX);
      wr(`ELPC_ADDR_CTRL, 8'h00);
      fe_on <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("lna off", lna_pin_o, !cfg[6]);
   endtask
   task t_tx;
      wr(`ELPC_ADDR_EXT_PA_CONFIG, 8'h66);
      wr(`ELPC_ADDR_TX2ACC, 8'h01);
      fe_on <= 1'b1;
      wr(`ELPC_ADDR_CTRL, 8'h03);
      wait_hi(1'b1);
      chk("tx wait", n >= 18 && n <= 28, 32'h1);
      chk("pa on", pa_pin_o, 32'h1);
      chk("tx state", radio_state_o, `ELPC_RF_TX_PA);
      wr(`ELPC_ADDR_CTRL, 8'h02);
      wait_hi(1'b0);
      chk("tx to rx", radio_state_o, `ELPC_RF_RX);
      chk("pa off", pa_pin_o, 32'h0);
      wr(`ELPC_ADDR_CTRL, 8'h00);
   endtask
   initial begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, fe_on} = 4'h0;
      adr_i = 10'h000;
      sel_i = 4'h0;
      dat_i = 32'h0;
      fe_wait = 8'h00;
      @(posedge clk_i);
      @(negedge clk_i);
      chk("lna in reset", lna_pin_o, 32'h1);
      @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_rx(8'h25, 16, 24, 8'd2);
      t_rx(8'h65, 50, 70, 8'd60);
      t_rx(8'h1f, 2, 14, 8'd4);
      t_tx();
      wrap_up();
   end
   initial begin
      #80000;
      n_mismatch++;
      wrap_up();
   end
endmodule
bind elpc_top elpc_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .err_o,
   .rx_settled_i, .rx_valid_o, .tx_access_o, .radio_state_o);
